// [shared/lin_err_flags_map.vh]
// Register map, field positions and codes for the LIN error flag bank
// How it works
// RULE1: In LIN mode a received checksum mismatch sets the checksum flag, bit 29.
// RULE2: Checksum type select picks classic or enhanced sum for the compare.
// RULE3: Checksum flag clears on vector read, module reset, software reset, system reset. Here a vector read clears it only while no synch flag is set.
// RULE4: Writing 1 clears the checksum flag; writing 0 leaves it alone.
// RULE5: Checksum flag reads 0 with no error recorded, 1 after one.
// RULE6: In LIN mode an inconsistent synch field sets the synch flag, bit 28.
// RULE7: Synch flag clears on vector read, resets, or a written 1.
// RULE8: Synch flag reads 1 after detection; writing 0 does nothing.
// RULE9: Flags stay set across frames until cleared; repeat detections keep them set.
`ifndef LIN_ERR_FLAGS_MAP_VH
`define LIN_ERR_FLAGS_MAP_VH

// Byte offsets of the registers
`define OFS_GLOBAL_CONTROL_ONE 5'h00
`define OFS_FLAGS              5'h04
`define OFS_VECTOR             5'h08
`define OFS_IRQ_STATUS         5'h0c
`define OFS_IRQ_MASK           5'h10

// Fields of global_control_one
`define GC_LIN_MODE            0
`define GC_CHECKSUM_TYPE       1
`define GC_MODULE_RESET        2
`define GC_SW_RESET            3

// Flag positions in the flags register
`define FLAG_CHECKSUM          29
`define FLAG_SYNCH             28

// Bit positions in the interrupt status and mask registers
`define IRQ_CHECKSUM           1
`define IRQ_SYNCH              0

// Interrupt vector offset codes
`define VEC_NONE               8'h00
`define VEC_SYNCH              8'h01
`define VEC_CHECKSUM           8'h02

// Reset values
`define RST_CONTROL            4'h0
`define RST_IRQ                2'h0

// AXI responses
`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2

`endif

// [rtl/lin_err_flags.v]
// Checksum and synch field error flags with AXI4-Lite register access
`timescale 1ns/100ps
`include "lin_err_flags_map.vh"

module lin_err_flags
#(
    parameter ADDR_W = 5,
    parameter SUM_W  = 8
)
(
    input  wire              clk,
    input  wire              nrst,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    input  wire              resp_done,
    input  wire [SUM_W-1:0]  resp_checksum,
    input  wire [SUM_W-1:0]  classic_sum,
    input  wire [SUM_W-1:0]  enhanced_sum,
    input  wire              sync_inconsistent,
    output reg               irq
);

    // Control bits
    reg              lin_mode;
    reg              checksum_type_select;
    reg              module_reset;
    reg              software_reset_control;

    // Sticky error flags
    wire             checksum_error_flag;
    wire             synch_field_error_flag;

    // Interrupt status and mask
    wire [1:0]       irq_status;
    reg  [1:0]       irq_mask;

    // Held write address and data
    reg  [ADDR_W-1:0] aw_addr_q;
    reg  [31:0]       w_data_q;
    reg  [3:0]        w_strb_q;

    // Next values
    wire             next_checksum_error_flag;
    wire             next_synch_field_error_flag;
    wire [1:0]       next_irq_status;
    reg  [31:0]      read_value;
    reg  [1:0]       read_resp;
    reg  [7:0]       vector_code;

    wire             held_in_reset;
    wire             ar_hs;
    wire             do_write;
    wire             read_vector;
    wire             read_status;
    wire [SUM_W-1:0] expected_sum;
    wire             checksum_event;
    wire             synch_event;
    wire             wr_flags;
    wire             vec_clr_checksum;
    wire             vec_clr_synch;
    wire             clr_checksum;
    wire             clr_synch;

    // Module reset bit high or software reset bit low holds flags clear
    assign held_in_reset = module_reset | ~software_reset_control;

    // Expected sum follows the selected checksum variant
    assign expected_sum = checksum_type_select ? enhanced_sum : classic_sum; // RULE2

    // Detections count only in LIN mode and outside module resets
    assign checksum_event = resp_done & lin_mode & ~held_in_reset
                            & (resp_checksum != expected_sum); // RULE1
    assign synch_event    = sync_inconsistent & lin_mode & ~held_in_reset; // RULE6

    // Bus strobes
    assign ar_hs       = s_axi_arvalid & s_axi_arready;
    assign do_write    = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    assign read_vector = ar_hs & (s_axi_araddr == `OFS_VECTOR);
    assign read_status = ar_hs & (s_axi_araddr == `OFS_IRQ_STATUS);
    assign wr_flags    = do_write & (aw_addr_q == `OFS_FLAGS) & w_strb_q[3];

    // Vector read clears only the flag it reports
    assign vec_clr_synch    = read_vector & synch_field_error_flag; // RULE7
    assign vec_clr_checksum = read_vector & ~synch_field_error_flag
                              & checksum_error_flag; // RULE3

    // Highest priority pending source; synch ahead of checksum
    always @*
    begin
        if (synch_field_error_flag)
            vector_code = `VEC_SYNCH;
        else if (checksum_error_flag)
            vector_code = `VEC_CHECKSUM;
        else
            vector_code = `VEC_NONE;
    end

    // Clears: a written 1 or a vector read that names the flag
    assign clr_checksum = (wr_flags & w_data_q[`FLAG_CHECKSUM]) | vec_clr_checksum; // RULE4
    assign clr_synch    = (wr_flags & w_data_q[`FLAG_SYNCH]) | vec_clr_synch; // RULE7

    // Checksum error flag; a detection in the clearing cycle wins
    sticky_bit checksum_flag_bit
    (
        .clk       (clk),
        .nrst      (nrst),
        .set_evt   (checksum_event), // RULE9
        .clr_evt   (clr_checksum), // RULE3
        .hold_clr  (held_in_reset), // RULE3
        .next_flag (next_checksum_error_flag),
        .flag      (checksum_error_flag)
    );

    // Synch field error flag; reset bits override everything
    sticky_bit synch_flag_bit
    (
        .clk       (clk),
        .nrst      (nrst),
        .set_evt   (synch_event), // RULE9
        .clr_evt   (clr_synch), // RULE7
        .hold_clr  (held_in_reset), // RULE7
        .next_flag (next_synch_field_error_flag),
        .flag      (synch_field_error_flag)
    );

    // Checksum status bit: sticky, a status read clears it
    sticky_bit checksum_status_bit
    (
        .clk       (clk),
        .nrst      (nrst),
        .set_evt   (checksum_event),
        .clr_evt   (read_status),
        .hold_clr  (held_in_reset),
        .next_flag (next_irq_status[`IRQ_CHECKSUM]),
        .flag      (irq_status[`IRQ_CHECKSUM])
    );

    // Synch status bit: sticky, a status read clears it
    sticky_bit synch_status_bit
    (
        .clk       (clk),
        .nrst      (nrst),
        .set_evt   (synch_event),
        .clr_evt   (read_status),
        .hold_clr  (held_in_reset),
        .next_flag (next_irq_status[`IRQ_SYNCH]),
        .flag      (irq_status[`IRQ_SYNCH])
    );

    // Read data mux; unmapped addresses answer SLVERR with zero data
    always @*
    begin
        read_value = 32'h0000_0000;
        read_resp  = `RESP_OKAY;
        case (s_axi_araddr)
            `OFS_GLOBAL_CONTROL_ONE:
            begin
                read_value[`GC_LIN_MODE]      = lin_mode;
                read_value[`GC_CHECKSUM_TYPE] = checksum_type_select;
                read_value[`GC_MODULE_RESET]  = module_reset;
                read_value[`GC_SW_RESET]      = software_reset_control;
            end
            `OFS_FLAGS:
            begin
                read_value[`FLAG_CHECKSUM] = checksum_error_flag; // RULE5
                read_value[`FLAG_SYNCH]    = synch_field_error_flag; // RULE8
            end
            `OFS_VECTOR:
                read_value[7:0] = vector_code;
            `OFS_IRQ_STATUS:
                read_value[1:0] = irq_status;
            `OFS_IRQ_MASK:
                read_value[1:0] = irq_mask;
            default:
                read_resp = `RESP_SLVERR;
        endcase
    end

    // Interrupt output, follows the status bits in the same cycle
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            // Registered so irq comes straight from a flop
            irq <= |(next_irq_status & irq_mask);
        end
    end

    // Control and mask registers, written on the commit cycle
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lin_mode               <= 1'b0;
            checksum_type_select   <= 1'b0;
            module_reset           <= 1'b0;
            software_reset_control <= 1'b0;
            irq_mask               <= `RST_IRQ;
        end
        else if (do_write && w_strb_q[0])
        begin
            if (aw_addr_q == `OFS_GLOBAL_CONTROL_ONE)
            begin
                lin_mode               <= w_data_q[`GC_LIN_MODE];
                checksum_type_select   <= w_data_q[`GC_CHECKSUM_TYPE];
                module_reset           <= w_data_q[`GC_MODULE_RESET];
                software_reset_control <= w_data_q[`GC_SW_RESET];
            end
            if (aw_addr_q == `OFS_IRQ_MASK)
                irq_mask <= w_data_q[1:0];
        end
    end

    // Write channels: take address and data in either order, one at a time
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            aw_addr_q     <= {ADDR_W{1'b0}};
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            // Commit one cycle after both are held
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                case (aw_addr_q)
                    `OFS_GLOBAL_CONTROL_ONE,
                    `OFS_FLAGS,
                    `OFS_VECTOR,
                    `OFS_IRQ_STATUS,
                    `OFS_IRQ_MASK:
                        s_axi_bresp <= `RESP_OKAY;
                    default:
                        s_axi_bresp <= `RESP_SLVERR;
                endcase
            end
            // Readiness returns only after the response is taken
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read channel: data and side effects both fixed at the address edge
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end
        else if (ar_hs)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= read_value;
            s_axi_rresp   <= read_resp;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// One sticky bit: a held clear beats a set, and a set beats a clear
module sticky_bit
(
    input  wire clk,
    input  wire nrst,
    input  wire set_evt,
    input  wire clr_evt,
    input  wire hold_clr,
    output reg  next_flag,
    output reg  flag
);

    // Next value; a set in a clearing cycle is kept so no event is lost
    always @*
    begin
        next_flag = flag;
        if (clr_evt)
            next_flag = 1'b0;
        if (set_evt)
            next_flag = 1'b1; // RULE9
        // Held module or software reset overrides both
        if (hold_clr)
            next_flag = 1'b0;
    end

    // Bit register
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            flag <= 1'b0;
        else
            flag <= next_flag;
    end

endmodule

// [test/lin_err_flags_properties.sv]
// Port-level checks for the LIN error flag bank
`timescale 1ns/100ps
`include "lin_err_flags_map.vh"

module lin_err_flags_props
#(
    parameter ADDR_W = 5
)
(
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic              resp_done,
    input wire logic              sync_inconsistent,
    input wire logic              irq
);
    logic [ADDR_W-1:0] ra;
    wire               ar_hs = s_axi_arvalid && s_axi_arready;

    // Address of the read in flight, so data can be judged by register
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ra <= '0;
        else if (ar_hs)
            ra <= s_axi_araddr;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_rd_lat; ar_hs |=> s_axi_rvalid; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_ar_low; ar_hs |=> !s_axi_arready; endproperty
    a_ar_low: assert property (p_ar_low) else $error("second read taken");
    property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
    property p_wr_resp;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
    property p_flags_bits;
        s_axi_rvalid && ra == `OFS_FLAGS |-> s_axi_rdata[27:0] == 0 && s_axi_rdata[31:30] == 0;
    endproperty
    a_flags_bits: assert property (p_flags_bits) else $error("stray flag bits");
    property p_vec_code; s_axi_rvalid && ra == `OFS_VECTOR |-> s_axi_rdata <= 32'h2; endproperty
    a_vec_code: assert property (p_vec_code) else $error("bad vector code");
    property p_unmapped; s_axi_rvalid && ra > 5'h10 |-> s_axi_rresp == 2'h2 && s_axi_rdata == 0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
    property p_irq_rise;
        $rose(irq) |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(resp_done || sync_inconsistent);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq without event");

    c_irq: cover property ($rose(irq));
    c_vec: cover property (s_axi_rvalid && ra == `OFS_VECTOR && s_axi_rdata != 0);
    c_bad: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind lin_err_flags lin_err_flags_props #(.ADDR_W(ADDR_W)) u_props
(
    .clk(clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .resp_done(resp_done), .sync_inconsistent(sync_inconsistent),
    .irq(irq)
);

// [test/lin_node_model.sv]
// Far-side LIN node: presents checksums and synch faults
`timescale 1ns/100ps

module lin_node_model
(
    input  wire logic  clk,
    output logic       resp_done,
    output logic [7:0] resp_checksum,
    output logic [7:0] classic_sum,
    output logic [7:0] enhanced_sum,
    output logic       sync_inconsistent
);
    logic [7:0] noise = 8'h00;
    logic [7:0] rx    = 8'h00;
    logic       act   = 1'b0;

    // Junk outside a frame, so a stale byte can never pass for a match
    always @(posedge clk)
        noise <= noise + 8'h3b;
    assign resp_checksum = act ? rx : ~noise;
    assign classic_sum   = act ? 8'h5a : noise;
    assign enhanced_sum  = act ? 8'ha5 : noise ^ 8'h55;

    initial
    begin
        resp_done = 1'b0;
        sync_inconsistent = 1'b0;
    end

    // One received checksum byte, valid for a single cycle
    task resp(input logic [7:0] b);
        @(posedge clk);
        rx <= b;
        act <= 1'b1;
        resp_done <= 1'b1;
        @(posedge clk);
        act <= 1'b0;
        resp_done <= 1'b0;
    endtask

    // One inconsistent synch field
    task sync_err;
        @(posedge clk);
        sync_inconsistent <= 1'b1;
        @(posedge clk);
        sync_inconsistent <= 1'b0;
    endtask
endmodule

// [test/testbench.sv]
// Self-checking bench for the LIN error flag bank
`timescale 1ns/100ps

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end

module testbench;
    typedef struct packed {logic [3:0] ctl; logic [7:0] rx; logic syn; logic [31:0] exp;} row_t;
    logic        clk = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0;
    logic        rry = 1'b0;
    logic [4:0]  awa = 5'h00, ara = 5'h00;
    logic [31:0] wd = 32'h0, rdat;
    logic [3:0]  strb = 4'hf;
    wire         awr, wr_rdy, bv, arr, rv, irq, done, syn;
    wire [1:0]   br, rr;
    wire [31:0]  rd_data;
    wire [7:0]   cks, csum, esum;
    int          error_cnt = 0, n_checks = 0;
    row_t        rows [8] = '{'{4'h9, 8'h5a, 1'b0, 32'h0}, '{4'h9, 8'ha5, 1'b0, 32'h2000_0000},
        '{4'hb, 8'ha5, 1'b0, 32'h0}, '{4'hb, 8'h5a, 1'b0, 32'h2000_0000},
        '{4'h8, 8'h00, 1'b1, 32'h0}, '{4'h9, 8'h5a, 1'b1, 32'h1000_0000},
        '{4'h1, 8'h00, 1'b1, 32'h0}, '{4'hd, 8'h00, 1'b1, 32'h0}};

    lin_err_flags dut
    (
        .clk(clk), .nrst(nrst), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_data), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rry), .resp_done(done), .resp_checksum(cks),
        .classic_sum(csum), .enhanced_sum(esum), .sync_inconsistent(syn), .irq(irq)
    );
    lin_node_model node
    (
        .clk(clk), .resp_done(done), .resp_checksum(cks), .classic_sum(csum),
        .enhanced_sum(esum), .sync_inconsistent(syn)
    );

    always #2.5 clk = ~clk;

    // Each transfer starts on a fresh edge, so no strobe is set twice at once
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (awr) awv <= 1'b0;
            if (wr_rdy) wv <= 1'b0;
        end
        while (!bv && n < 50);
        bry <= 1'b0;
        `CHK("bresp", (a > 5'h10) ? 2'h2 : 2'h0, br)
    endtask

    task automatic rd(input logic [4:0] a);
        int n = 0;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (arr) arv <= 1'b0;
        end
        while (!rv && n < 50);
        rry <= 1'b0;
        rdat = rd_data;
        `CHK("rresp", (a > 5'h10) ? 2'h2 : 2'h0, rr)
    endtask

    task automatic rdx(input logic [4:0] a, input logic [31:0] e);
        rd(a);
        `CHK("rdata", e, rdat)
    endtask

    // Let the edge's updates land before looking at irq
    task settle;
        @(posedge clk);
        #1;
    endtask

    task end_sim;
        $display("Checks made %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        rdx(5'h00, 0);
        rdx(5'h04, 0);
        for (int i = 0; i < 8; i++)
        begin
            wr(5'h00, {28'h0, rows[i].ctl});
            wr(5'h04, 32'h3000_0000);
            node.resp(rows[i].rx);
            if (rows[i].syn) node.sync_err();
            rdx(5'h04, rows[i].exp);
        end
        wr(5'h00, 32'h9);
        node.resp(8'ha5);
        node.sync_err();
        wr(5'h04, 32'h0);
        rdx(5'h04, 32'h3000_0000);
        strb <= 4'h7;
        wr(5'h04, 32'h3000_0000);
        strb <= 4'he;
        wr(5'h00, 32'h0);
        strb <= 4'hf;
        rdx(5'h04, 32'h3000_0000);
        rdx(5'h00, 32'h9);
        node.resp(8'ha5);
        node.resp(8'h5a);
        rdx(5'h04, 32'h3000_0000);
        wr(5'h04, 32'h2000_0000);
        rdx(5'h04, 32'h1000_0000);
        wr(5'h04, 32'h1000_0000);
        rdx(5'h04, 32'h0);
        node.resp(8'ha5);
        node.sync_err();
        rdx(5'h08, 32'h1);
        rdx(5'h04, 32'h2000_0000);
        rdx(5'h08, 32'h2);
        rdx(5'h04, 32'h0);
        rdx(5'h08, 32'h0);
        node.resp(8'ha5);
        node.sync_err();
        wr(5'h00, 32'hd);
        rdx(5'h04, 32'h0);
        wr(5'h00, 32'h9);
        node.sync_err();
        wr(5'h00, 32'h1);
        rdx(5'h04, 32'h0);
        wr(5'h00, 32'h9);
        rd(5'h0c);
        wr(5'h10, 32'h3);
        node.sync_err();
        settle();
        `CHK("irq", 1'b1, irq)
        rdx(5'h0c, 32'h1);
        settle();
        `CHK("irq", 1'b0, irq)
        wr(5'h10, 32'h0);
        node.resp(8'ha5);
        settle();
        `CHK("irq", 1'b0, irq)
        rdx(5'h0c, 32'h2);
        wr(5'h14, 32'hffff_ffff);
        rdx(5'h14, 32'h0);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rdx(5'h04, 32'h0);
        rdx(5'h00, 32'h0);
        end_sim();
    end

    // Whole run is under 300 cycles; this cuts a hang short
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_sim();
    end
endmodule
